// [shared/dvel_pkg.sv]
// Shared constants and types for the function-enable and ECC error log block.
// Assumes configuration offsets are byte offsets within function 0 config space.
package dvel_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets and reset values
    localparam logic [7:0]  FE_OFFSET  = 8'h54;
    localparam logic [7:0]  LOG_OFFSET = 8'h58;
    localparam logic [31:0] FE_RESET   = 32'h0000_0003;
    localparam logic [31:0] LOG_RESET  = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int FE_HOST_BIT   = 0;
    localparam int FE_PORT_A_BIT = 1;
    localparam int FE_PORT_B_BIT = 2;
    localparam int LOG_ADDR_LSB  = 7;
    localparam int LOG_ADDR_MSB  = 31;
    localparam int LOG_CHAN_BIT  = 0;
    localparam int ADDR_W        = LOG_ADDR_MSB - LOG_ADDR_LSB + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Reset synchroniser depth for the power-good domain
    localparam int PG_SYNC_STAGES = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef logic [ADDR_W-1:0] dvel_addr_t;

    typedef enum logic [1:0] {
        LOG_OPEN,
        LOG_SINGLE,
        LOG_LOCKED
    } dvel_log_e;

endpackage : dvel_pkg

// [shared/dvel_log_if.sv]
// Carrier between the register bank and the sticky error log.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface dvel_log_if;
    import dvel_pkg::*;

    // Error events, passed through unqualified by the register bank
    logic       event_single;
    logic       event_multi;
    dvel_addr_t event_addr;
    logic       event_channel;
    logic       flags_clear;

    // Sticky log contents
    dvel_addr_t log_addr;
    logic       log_channel;
    dvel_log_e  log_mode;

    modport bank (
        output event_single,
        output event_multi,
        output event_addr,
        output event_channel,
        output flags_clear,
        input  log_addr,
        input  log_channel,
        input  log_mode
    );

    modport log (
        input  event_single,
        input  event_multi,
        input  event_addr,
        input  event_channel,
        input  flags_clear,
        output log_addr,
        output log_channel,
        output log_mode
    );

endinterface : dvel_log_if

// [src/dvel_error_log.sv]
// Sticky first-error address and channel log.
// Assumes i_power_good is the only reset; platform reset does not reach it.
`timescale 1ns/1ps

module dvel_error_log (
    // Clock and power-good reset
    input  wire logic i_clock,
    input  wire logic i_power_good,
    // Link to the register bank
    dvel_log_if.log   lg
);
    import dvel_pkg::*;

    typedef struct packed {
        logic [PG_SYNC_STAGES-1:0] sync;
        dvel_log_e                 mode;
        dvel_addr_t                addr;
        logic                      channel;
    } dvel_log_s;

    dvel_log_s state;
    dvel_log_s next_state;

    ////////////////////////////////////////////////////////////////////////////
    // Capture policy
    always_comb begin
        logic      live;
        logic      any_err;
        logic      clear;
        dvel_log_e cur;
        live    = state.sync[PG_SYNC_STAGES-1];
        any_err = live & (lg.event_single | lg.event_multi);
        clear   = live & lg.flags_clear;
        next_state      = state;
        next_state.sync = {state.sync[PG_SYNC_STAGES-2:0], 1'b1};
        // A clear in the same cycle as an error reopens the log first
        cur = clear ? LOG_OPEN : state.mode;
        next_state.mode = cur;
        case (cur)
            LOG_OPEN: begin
                if (any_err) begin
                    next_state.addr    = lg.event_addr;
                    next_state.channel = lg.event_channel;
                    next_state.mode    = lg.event_multi ? LOG_LOCKED : LOG_SINGLE;
                end
            end
            LOG_SINGLE: begin
                if (live & lg.event_multi) begin
                    next_state.addr    = lg.event_addr;
                    next_state.channel = lg.event_channel;
                    next_state.mode    = LOG_LOCKED;
                end
            end
            LOG_LOCKED: begin
                next_state.mode = LOG_LOCKED;
            end
            default: begin
                next_state.mode = LOG_OPEN;
            end
        endcase
    end

    // Only power-good clears the log
    always_ff @(posedge i_clock or negedge i_power_good) begin
        if (!i_power_good) begin
            state.sync    <= '0;
            state.mode    <= LOG_OPEN;
            state.addr    <= LOG_RESET[LOG_ADDR_MSB:LOG_ADDR_LSB];
            state.channel <= LOG_RESET[LOG_CHAN_BIT];
        end else begin
            state <= next_state;
        end
    end

    assign lg.log_addr    = state.addr;
    assign lg.log_channel = state.channel;
    assign lg.log_mode    = state.mode;

endmodule : dvel_error_log

// [src/dvel_top.sv]
// Function-enable control and DRAM ECC error address log, config space function 0.
// Contract
// - Host bridge enable bit reads one always
// - Bit 1 zero hides root port A
// - Bit 2 controls root port B, else reserved
// - Log failing address bits 31:7 on errors
// - Logged address is post-remap logical address
// - Capture first error after flags cleared
// - Multi-bit error locks the address field
// - Log cleared only by power-good loss
// - Bit 0 records failing memory channel
// Assumes a single-cycle config request port and same-clock ECC event pulses.
`timescale 1ns/1ps

module dvel_top #(
    parameter bit HAS_PORT_B = 1'b1
) (
    // Clock and resets
    input  wire logic                 i_clock,
    input  wire logic                 i_reset_n,
    input  wire logic                 i_power_good,
    // Configuration register access
    input  wire logic                 i_cfg_req,
    input  wire logic                 i_cfg_write,
    input  wire logic [7:0]           i_cfg_offset,
    input  wire logic [3:0]           i_cfg_byte_en,
    input  wire logic [31:0]          i_cfg_wdata,
    output      logic                 o_cfg_ack,
    output      logic                 o_cfg_claim,
    output      logic [31:0]          o_cfg_rdata,
    // ECC events from the memory controller
    input  wire logic                 i_ecc_single,
    input  wire logic                 i_ecc_multi,
    input  wire dvel_pkg::dvel_addr_t i_ecc_logical_addr,
    input  wire logic                 i_ecc_channel,
    input  wire logic                 i_error_flags_clear,
    // Function enables
    output      logic                 o_host_bridge_enable,
    output      logic                 o_root_port_a_enable,
    output      logic                 o_root_port_b_enable
);
    import dvel_pkg::*;

    typedef struct packed {
        logic        ack;
        logic        claim;
        logic [31:0] rdata;
        logic        port_a;
        logic        port_b;
    } dvel_bank_s;

    dvel_bank_s state;
    dvel_bank_s next_state;

    dvel_log_if lg ();

    ////////////////////////////////////////////////////////////////////////////
    // Sticky log, on its own reset
    dvel_error_log dvel_error_log_i (
        .i_clock      (i_clock),
        .i_power_good (i_power_good),
        .lg           (lg.log)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Error events toward the log
    // The address arrives already translated through the remap window
    assign lg.event_single  = i_ecc_single;
    assign lg.event_multi   = i_ecc_multi;
    assign lg.event_addr    = i_ecc_logical_addr;
    assign lg.event_channel = i_ecc_channel;
    assign lg.flags_clear   = i_error_flags_clear;

    ////////////////////////////////////////////////////////////////////////////
    // Register decode, write and read-back
    always_comb begin
        logic        hit_fe;
        logic        hit_log;
        logic [31:0] fe_view;
        logic [31:0] log_view;
        hit_fe   = i_cfg_offset[7:2] == FE_OFFSET[7:2];
        hit_log  = i_cfg_offset[7:2] == LOG_OFFSET[7:2];
        fe_view  = '0;
        log_view = '0;
        fe_view[FE_HOST_BIT]   = 1'b1;
        fe_view[FE_PORT_A_BIT] = state.port_a;
        fe_view[FE_PORT_B_BIT] = HAS_PORT_B & state.port_b;
        log_view[LOG_ADDR_MSB:LOG_ADDR_LSB] = lg.log_addr;
        log_view[LOG_CHAN_BIT] = lg.log_channel;
        next_state       = state;
        next_state.ack   = i_cfg_req;
        next_state.claim = i_cfg_req & (hit_fe | hit_log);
        next_state.rdata = '0;
        if (i_cfg_req && i_cfg_write) begin
            // Only the low byte holds writable bits; the log is read-only
            if (hit_fe && i_cfg_byte_en[0]) begin
                next_state.port_a = i_cfg_wdata[FE_PORT_A_BIT];
                next_state.port_b = HAS_PORT_B & i_cfg_wdata[FE_PORT_B_BIT];
            end
        end else if (i_cfg_req) begin
            if (hit_fe) begin
                next_state.rdata = fe_view;
            end else if (hit_log) begin
                next_state.rdata = log_view;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state.ack    <= 1'b0;
            state.claim  <= 1'b0;
            state.rdata  <= '0;
            state.port_a <= FE_RESET[FE_PORT_A_BIT];
            state.port_b <= HAS_PORT_B & FE_RESET[FE_PORT_B_BIT];
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_cfg_ack            = state.ack;
    assign o_cfg_claim          = state.claim;
    assign o_cfg_rdata          = state.rdata;
    assign o_host_bridge_enable = 1'b1;
    assign o_root_port_a_enable = state.port_a;
    assign o_root_port_b_enable = HAS_PORT_B & state.port_b;

endmodule : dvel_top

// [tb/dvel_top_properties.sv]
// Checker for the function-enable and error log block
// Assumes it is bound onto dvel_top and sees only its ports
`timescale 1ns/1ps
module dvel_properties #(
    parameter bit HAS_PORT_B = 1'b1
) (
    // Clock and reset
    input wire logic                 i_clock,
    input wire logic                 i_reset_n,
    // Config port
    input wire logic                 i_cfg_req,
    input wire logic                 i_cfg_write,
    input wire logic [7:0]           i_cfg_offset,
    input wire logic [3:0]           i_cfg_byte_en,
    input wire logic [31:0]          i_cfg_wdata,
    input wire logic                 o_cfg_ack,
    input wire logic                 o_cfg_claim,
    input wire logic [31:0]          o_cfg_rdata,
    // Events and enables
    input wire logic                 i_ecc_multi,
    input wire dvel_pkg::dvel_addr_t i_ecc_logical_addr,
    input wire logic                 i_ecc_channel,
    input wire logic                 i_error_flags_clear,
    input wire logic                 o_host_bridge_enable,
    input wire logic                 o_root_port_a_enable,
    input wire logic                 o_root_port_b_enable
);
    import dvel_pkg::*;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    wire fe = i_cfg_offset[7:2] == 6'h15;
    wire lg = i_cfg_offset[7:2] == 6'h16;
    wire rd_fe = i_cfg_req && !i_cfg_write && fe;
    wire rd_lg = i_cfg_req && !i_cfg_write && lg;
    wire wr_fe = i_cfg_req && i_cfg_write && fe && i_cfg_byte_en[0];
    sequence s_reopen_multi;
        i_error_flags_clear && i_ecc_multi;
    endsequence
    sequence s_quiet_then_read;
        !i_error_flags_clear ##1 rd_lg;
    endsequence
    property p_capture;
        s_reopen_multi ##1 s_quiet_then_read
            |=> o_cfg_rdata == {$past(i_ecc_logical_addr, 3), 6'h00, $past(i_ecc_channel, 3)};
    endproperty
    property p_ack; o_cfg_ack == $past(i_cfg_req); endproperty
    property p_host; o_host_bridge_enable; endproperty
    property p_fe_read; rd_fe |=> o_cfg_rdata[0] && o_cfg_rdata[31:3] == 29'h0; endproperty
    property p_port_a; wr_fe |=> o_root_port_a_enable == $past(i_cfg_wdata[1]); endproperty
    property p_port_b;
        wr_fe |=> o_root_port_b_enable == (HAS_PORT_B && $past(i_cfg_wdata[2]));
    endproperty
    property p_hold;
        !wr_fe |=> $stable({o_root_port_a_enable, o_root_port_b_enable});
    endproperty
    property p_unmapped;
        i_cfg_req && !fe && !lg |=> o_cfg_ack && !o_cfg_claim && o_cfg_rdata == 32'h0;
    endproperty
    property p_log_rsv; rd_lg |=> o_cfg_ack && o_cfg_rdata[6:1] == 6'h00; endproperty
    a_capture: assert property (p_capture) else $error("missed capture");
    a_host: assert property (p_host) else $error("host bridge off");
    a_fe_read: assert property (p_fe_read) else $error("enable read bad");
    a_port_a: assert property (p_port_a) else $error("port a wrong");
    a_port_b: assert property (p_port_b) else $error("port b wrong");
    a_hold: assert property (p_hold) else $error("enable moved");
    a_unmapped: assert property (p_unmapped) else $error("unmapped claimed");
    a_log_rsv: assert property (p_log_rsv) else $error("log reserved set");
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
endmodule : dvel_properties
bind dvel_top dvel_properties #(.HAS_PORT_B(HAS_PORT_B)) dvel_properties_i (.*);

// [tb/dvel_top_test.sv]
// Self-checking bench for the function-enable and error log block
// Assumes dvel_top with both root ports present
`timescale 1ns/1ps
module dvel_top_test;
    import dvel_pkg::*;
    logic i_clock = 1'b0, i_reset_n = 1'b0, i_power_good = 1'b0;
    logic i_cfg_req = 1'b0, i_cfg_write = 1'b0, i_ecc_single = 1'b0, i_ecc_multi = 1'b0;
    logic i_ecc_channel = 1'b0, i_error_flags_clear = 1'b0, cl;
    logic [7:0] i_cfg_offset = 8'h00;
    logic [3:0] i_cfg_byte_en = 4'h0;
    logic [31:0] i_cfg_wdata = 32'h0, rd, o_cfg_rdata;
    dvel_addr_t i_ecc_logical_addr = '0;
    logic o_cfg_ack, o_cfg_claim, o_host_bridge_enable;
    logic o_root_port_a_enable, o_root_port_b_enable;
    int mismatches = 0, compares = 0;
    always #50 i_clock = ~i_clock;
    dvel_top dvel_top_i (.*);
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    // Starts at a falling edge, ends one idle cycle after the ack
    task automatic cfg(input logic w, input logic [7:0] o, input logic [3:0] b,
                       input logic [31:0] d);
        int n;
        {i_cfg_req, i_cfg_write, i_cfg_offset, i_cfg_byte_en, i_cfg_wdata} = {1'b1, w, o, b, d};
        @(negedge i_clock);
        i_cfg_req = 1'b0;
        for (n = 0; n < 4 && o_cfg_ack !== 1'b1; n++) begin
            @(negedge i_clock);
        end
        if (n == 4) begin
            mismatches++;
            summarize();
        end
        rd = o_cfg_rdata;
        cl = o_cfg_claim;
        @(negedge i_clock);
    endtask : cfg
    task automatic rdchk(input logic [7:0] o, input logic [31:0] e);
        cfg(1'b0, o, 4'h0, 32'h0);
        check(rd, e);
    endtask : rdchk
    task automatic ev(input logic s, input logic m, input logic c, input dvel_addr_t a,
                      input logic ch);
        {i_ecc_single, i_ecc_multi, i_error_flags_clear, i_ecc_logical_addr, i_ecc_channel}
            = {s, m, c, a, ch};
        @(negedge i_clock);
        {i_ecc_single, i_ecc_multi, i_error_flags_clear} = 3'h0;
        @(negedge i_clock);
    endtask : ev
    function automatic logic [31:0] en();
        return {29'h0, o_root_port_b_enable, o_root_port_a_enable, o_host_bridge_enable};
    endfunction : en
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check(en(), FE_RESET);
        rdchk(FE_OFFSET, FE_RESET);
        rdchk(LOG_OFFSET, LOG_RESET);
        $display("test reset done");
    endtask : t_reset
    task automatic t_enable;
        cfg(1'b1, FE_OFFSET, 4'h1, 32'h0);
        rdchk(FE_OFFSET, 32'h1);
        check(en(), 32'h1);
        cfg(1'b1, FE_OFFSET, 4'hf, 32'hffffffff);
        rdchk(FE_OFFSET, 32'h7);
        check(en(), 32'h7);
        cfg(1'b1, FE_OFFSET, 4'he, 32'h0);
        rdchk(FE_OFFSET, 32'h7);
        cfg(1'b1, LOG_OFFSET, 4'hf, 32'hffffffff);
        rdchk(LOG_OFFSET, LOG_RESET);
        check({31'h0, cl}, 32'h1);
        rdchk(8'h5c, 32'h0);
        check({31'h0, cl}, 32'h0);
        $display("test enable done");
    endtask : t_enable
    task automatic t_log;
        ev(1'b1, 1'b0, 1'b1, 25'h0123456, 1'b0);
        rdchk(LOG_OFFSET, {25'h0123456, 7'h00});
        ev(1'b1, 1'b0, 1'b0, 25'h1fedcba, 1'b1);
        rdchk(LOG_OFFSET, {25'h0123456, 7'h00});
        ev(1'b0, 1'b1, 1'b0, 25'h1555555, 1'b1);
        rdchk(LOG_OFFSET, {25'h1555555, 7'h01});
        ev(1'b1, 1'b0, 1'b0, 25'h0aaaaaa, 1'b0);
        ev(1'b0, 1'b1, 1'b0, 25'h0123456, 1'b0);
        rdchk(LOG_OFFSET, {25'h1555555, 7'h01});
        ev(1'b0, 1'b0, 1'b1, 25'h0aaaaaa, 1'b0);
        rdchk(LOG_OFFSET, {25'h1555555, 7'h01});
        ev(1'b0, 1'b1, 1'b1, 25'h1fedcba, 1'b0);
        rdchk(LOG_OFFSET, {25'h1fedcba, 7'h00});
        $display("test log done");
    endtask : t_log
    task automatic t_sticky;
        i_reset_n = 1'b0;
        @(negedge i_clock);
        i_reset_n = 1'b1;
        check(en(), FE_RESET);
        rdchk(LOG_OFFSET, {25'h1fedcba, 7'h00});
        i_power_good = 1'b0;
        @(negedge i_clock);
        i_power_good = 1'b1;
        rdchk(LOG_OFFSET, LOG_RESET);
        $display("test sticky done");
    endtask : t_sticky
    initial begin
        @(negedge i_clock);
        i_power_good = 1'b1;
        repeat (6) @(negedge i_clock);
        i_reset_n = 1'b1;
        t_reset();
        t_enable();
        t_log();
        t_sticky();
        summarize();
    end
endmodule : dvel_top_test
